/* File: common/p6mux_pkg.sv */
// types shared by the pin 6 output source selector
package p6mux_pkg;
	typedef enum logic [2:0] {
		P6MUX_SRC_RX0  = 3'b000,
		P6MUX_SRC_RX1  = 3'b001,
		P6MUX_SRC_RX2  = 3'b010,
		P6MUX_SRC_RX3  = 3'b011,
		P6MUX_SRC_DEV  = 3'b100,
		P6MUX_SRC_RSV5 = 3'b101,
		P6MUX_SRC_TX   = 3'b110,
		P6MUX_SRC_RSV7 = 3'b111
	} p6mux_src_e;
	// per receive port status bundle
	typedef struct packed {
		logic [3:0] remote_pin;
		logic       lock;
		logic       pass;
		logic       frame_valid;
		logic       line_valid;
	} p6mux_rx_s;
	// transmit port status bundle
	typedef struct packed {
		logic pass_and;
		logic pass_or;
		logic frame_valid;
		logic line_valid;
		logic synced;
		logic irq;
	} p6mux_tx_s;
endpackage : p6mux_pkg

/* File: common/p6mux_regs.svh */
// register offsets, field positions and reset values of the pin 6 output control
`ifndef P6MUX_REGS_SVH
`define P6MUX_REGS_SVH
`define P6MUX_CTRL_OFFSET   8'h16
`define P6MUX_CTRL_ADDR     12'h058
`define P6MUX_CTRL_RESET    8'h00
`define P6MUX_SEL_MSB       7
`define P6MUX_SEL_LSB       5
`define P6MUX_SRC_MSB       4
`define P6MUX_SRC_LSB       2
`define P6MUX_VAL_BIT       1
`define P6MUX_EN_BIT        0
`define P6MUX_STATUS_ADDR   12'h05C
`define P6MUX_ENABLE_ADDR   12'h060
`define P6MUX_ENABLE_RESET  4'hF
`endif

/* File: sim/p6mux_pin_load.sv */
// board-side load on pin 6: a weak pull-down holds the wire low when undriven
`timescale 1ns/10ps
module p6mux_pin_load (
	input  wire logic pin6_o,
	input  wire logic pin6_oe,
	output logic      pin_level
);
	// released pin falls to the pull-down level, never the last driven value
	assign pin_level = pin6_oe ? pin6_o : 1'b0;
endmodule : p6mux_pin_load

/* File: sim/test_p6mux_top.sv */
// register-driven bench for the pin 6 output source selector
`timescale 1ns/10ps
`include "p6mux_regs.svh"
module test_p6mux_top
	import p6mux_pkg::*;
;
	logic aclk, aresetn, clk_en, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
	logic awready, wready, arready, pin6_o, pin6_oe, pin_level;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, pe;
	logic [1:0]  bresp, rresp, r;
	logic [7:0]  c;
	p6mux_rx_s   rx_stat [4];
	p6mux_tx_s   tx_stat;
	int          failures, n_tests, p, k;
	p6mux_top DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rx_stat(rx_stat), .tx_stat(tx_stat), .pin6_o(pin6_o),
		.pin6_oe(pin6_oe));
	p6mux_pin_load LOAD (.pin6_o(pin6_o), .pin6_oe(pin6_oe), .pin_level(pin_level));
	always #25 aclk = ~aclk;
	task automatic stop_test();
		if (failures == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// write: both channels offered together, each dropped once taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw, w;
		@(posedge aclk);
		aw = 1;
		w = 1;
		awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
		// no cycle count assumed: only the watchdog ends a wait that never answers
		do begin
			@(posedge aclk);
			if (aw && awready) begin aw = 0; awvalid <= 0; end
			if (w && wready) begin w = 0; wvalid <= 0; end
		end while (!(bvalid && !aw && !w));
		rs = bresp;
		bready <= 0;
	endtask : axi_wr
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ar;
		@(posedge aclk);
		ar = 1;
		araddr <= a; arvalid <= 1; rready <= 1;
		do begin
			@(posedge aclk);
			if (ar && arready) begin ar = 0; arvalid <= 0; end
		end while (!(rvalid && !ar));
		v = rdata;
		rs = rresp;
		rready <= 0;
	endtask : axi_rd
	// expected pin level worked out from the field encodings
	function automatic logic exp_pin(input logic [7:0] cv, input logic [3:0] en);
		logic lo, la, pa, v;
		lo = 0; la = |en; pa = |en; v = 0;
		for (int i = 0; i < 4; i++) if (en[i]) begin
			lo |= rx_stat[i].lock; la &= rx_stat[i].lock; pa &= rx_stat[i].pass;
		end
		if (cv[4:2] < 3'h4) case (cv[7:5])
			3'h0: v = rx_stat[cv[3:2]].remote_pin[0];
			3'h1: v = rx_stat[cv[3:2]].remote_pin[2];
			3'h3: v = rx_stat[cv[3:2]].remote_pin[3];
			3'h4: v = rx_stat[cv[3:2]].lock;
			3'h5: v = rx_stat[cv[3:2]].pass;
			3'h6: v = rx_stat[cv[3:2]].frame_valid;
			3'h7: v = rx_stat[cv[3:2]].line_valid;
			default: v = 0;
		endcase
		else if (cv[4:2] == 3'h4) v = (cv[7:5] == 3'h0) ? cv[1] : (cv[7:5] == 3'h1) ? lo :
			(cv[7:5] == 3'h2) ? la : (cv[7:5] == 3'h3) ? pa : 1'b0;
		else if (cv[4:2] == 3'h6 && cv[7:5] < 3'h6) v = tx_stat[3'h5 - cv[7:5]];
		return cv[0] & v;
	endfunction : exp_pin
	// time limit well beyond the roughly 1,600 cycles the sweep needs
	initial begin
		#500000;
		failures++;
		stop_test();
	end
	initial begin
		aclk = 0; aresetn = 0; clk_en = 1; wstrb = 4'hF; awaddr = 0; wdata = 0; awvalid = 0;
		wvalid = 0; bready = 0; araddr = 0; arvalid = 0; rready = 0; tx_stat = '0;
		for (int i = 0; i < 4; i++) rx_stat[i] = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		axi_rd(`P6MUX_CTRL_ADDR, d, r);
		chk(d, 32'h0000_0000);
		chk({pin6_oe, pin_level}, 2'h0);
		// four passes: status patterns flipped, enabled ports thinned, driver off at the end
		for (p = 0; p < 4; p++) begin
			for (int i = 0; i < 4; i++) rx_stat[i] <= 8'(8'hA5 ^ (8'h3C * i) ^ {8{p[0]}});
			tx_stat <= 6'h2B ^ {6{p[0]}};
			pe = (p == 1) ? 4'h6 : 4'hF;
			axi_wr(`P6MUX_ENABLE_ADDR, {28'h0, pe}, r);
			for (k = 0; k < 64; k++) begin
				c = {k[5:0], p[0], 1'(p != 3)};
				axi_wr(`P6MUX_CTRL_ADDR, {24'h0, c}, r);
				repeat (2) @(posedge aclk);
				chk(pin6_o, exp_pin(c, pe));
				chk({pin6_oe, pin_level}, {c[0], exp_pin(c, pe)});
			end
			axi_rd(`P6MUX_CTRL_ADDR, d, r);
			chk(d, {24'h0, c});
		end
		// clock enable low freezes the pin although its source moves
		rx_stat[0] <= 8'h08;
		axi_wr(`P6MUX_CTRL_ADDR, 32'h81, r);
		repeat (2) @(posedge aclk);
		chk(pin6_o, 1'b1);
		clk_en <= 0;
		rx_stat[0] <= 8'h00;
		repeat (3) @(posedge aclk);
		chk(pin6_o, 1'b1);
		clk_en <= 1;
		repeat (2) @(posedge aclk);
		chk(pin6_o, 1'b0);
		// status word shows the driver on with a low level
		axi_rd(`P6MUX_STATUS_ADDR, d, r);
		chk({r, d}, {2'h0, 32'h2});
		// second reset in mid-run clears the control register again
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		axi_rd(`P6MUX_CTRL_ADDR, d, r);
		chk(d, 32'h0);
		chk({pin6_oe, pin_level}, 2'h0);
		// unmapped place answers with an error and stores nothing
		axi_wr(12'h100, 32'hFF, r);
		chk(r, 2'h2);
		axi_rd(12'h100, d, r);
		chk({r, d}, {2'h2, 32'h0});
		axi_rd(`P6MUX_CTRL_ADDR, d, r);
		chk(d, 32'h0);
		stop_test();
	end
endmodule : test_p6mux_top

/* File: verilog/p6mux_top.sv */
// pin 6 output source selector with its control register on an AXI4-Lite slave
// Overview of operation
// RL1 - source field bits 4:2 picks rx port 0-3, device status or transmit port
// RL2 - rx source: select 000/001/011 give remote pins 0, 2, 3
// RL3 - rx source: select 100 drives lock, 101 drives pass
// RL4 - rx source: select 111 drives line valid; frame valid code is ambiguous
// RL5 - device source: select 001 drives OR of enabled ports' lock
// RL6 - device source: select 010 drives AND of enabled ports' lock
// RL7 - device source: select 011 drives AND of enabled ports' pass
// RL8 - transmit source: select 000 drives pass AND, 001 drives pass OR
// RL9 - transmit source: select 010 drives frame valid
// RL10 - transmit source: select 011 drives line valid
// RL11 - transmit source: select 100 drives multi-port synchronized flag
// RL12 - transmit source: select 101 drives transmit interrupt; 111 reserved
// RL13 - bit 1 is the local value driven when the register value is chosen
// RL14 - bit 0 enables the pin driver
// RL15 - control register resets to zero: driver off, rx port 0, select 0
// RL16 - device select 000 drives local value; reserved codes drive low
// RL17 - driver stays off while enable is clear whatever the selection
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "p6mux_regs.svh"
module p6mux_top
	import p6mux_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clk_en,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire p6mux_rx_s   rx_stat [4],
	input  wire p6mux_tx_s   tx_stat,
	output logic             pin6_o,
	output logic             pin6_oe
);

	// control register and port enable register
	logic [7:0] ctrl_ff;
	logic [3:0] port_en_ff;
	logic       aw_hold_ff;
	logic       w_hold_ff;
	logic [11:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic       pin_ff;
	logic       oe_ff;

	// field decode
	wire logic [2:0] pin6_signal_select = ctrl_ff[`P6MUX_SEL_MSB:`P6MUX_SEL_LSB];
	wire p6mux_src_e pin6_source_select = p6mux_src_e'(ctrl_ff[`P6MUX_SRC_MSB:`P6MUX_SRC_LSB]);
	wire logic       pin6_local_value   = ctrl_ff[`P6MUX_VAL_BIT];
	wire logic       pin6_drive_enable  = ctrl_ff[`P6MUX_EN_BIT];

	// write channel: address and data taken in either order, one write at a time
	wire logic aw_take   = s_axi_awvalid && s_axi_awready;
	wire logic w_take    = s_axi_wvalid && s_axi_wready;
	wire logic wr_go     = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
	wire logic wr_ctrl   = wr_go && (awaddr_ff == `P6MUX_CTRL_ADDR) && wstrb_ff[0];
	wire logic wr_en     = wr_go && (awaddr_ff == `P6MUX_ENABLE_ADDR) && wstrb_ff[0];
	wire logic wr_known  = (awaddr_ff == `P6MUX_CTRL_ADDR) || (awaddr_ff == `P6MUX_ENABLE_ADDR);

	// read decode; unmapped addresses answer slverr with zero data
	wire logic [11:0] ra = s_axi_araddr;
	// one read at a time: ready waits only for the previous answer, never for valid low
	wire logic        ar_take = s_axi_arvalid && s_axi_arready;
	wire logic        rd_ctrl = (ra == `P6MUX_CTRL_ADDR);
	wire logic        rd_stat = (ra == `P6MUX_STATUS_ADDR);
	wire logic        rd_pen  = (ra == `P6MUX_ENABLE_ADDR);
	wire logic [31:0] rd_word = rd_ctrl ? {24'h000000, ctrl_ff} :
	                            rd_stat ? {30'h0, oe_ff, pin_ff} :
	                            rd_pen  ? {28'h0000000, port_en_ff} : 32'h00000000;
	wire logic        rd_ok   = rd_ctrl || rd_stat || rd_pen;

	// aggregate status over enabled receive ports; no enabled port gives low
	logic [3:0] lock_v;
	logic [3:0] pass_v;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lock_v[i] = rx_stat[i].lock;
			pass_v[i] = rx_stat[i].pass;
		end
	end
	wire logic any_en   = |port_en_ff;
	wire logic lock_or  = |(lock_v & port_en_ff);                         // RL5
	wire logic lock_and = any_en && &(lock_v | ~port_en_ff);              // RL6
	wire logic pass_and = any_en && &(pass_v | ~port_en_ff);              // RL7

	// second level: signal within the chosen receive port
	wire p6mux_rx_s rx_sel = rx_stat[pin6_source_select[1:0]];
	logic rx_sig;
	always_comb begin
		case (pin6_signal_select)
			3'h0: rx_sig = rx_sel.remote_pin[0];     // RL2
			3'h1: rx_sig = rx_sel.remote_pin[2];     // RL2
			3'h3: rx_sig = rx_sel.remote_pin[3];     // RL2
			3'h4: rx_sig = rx_sel.lock;              // RL3
			3'h5: rx_sig = rx_sel.pass;              // RL3
			3'h6: rx_sig = rx_sel.frame_valid;       // RL4
			3'h7: rx_sig = rx_sel.line_valid;        // RL4
			default: rx_sig = 1'b0;                  // RL16
		endcase
	end

	// device status signals
	logic dev_sig;
	always_comb begin
		case (pin6_signal_select)
			3'h0: dev_sig = pin6_local_value;        // RL16 RL13
			3'h1: dev_sig = lock_or;                 // RL5
			3'h2: dev_sig = lock_and;                // RL6
			3'h3: dev_sig = pass_and;                // RL7
			default: dev_sig = 1'b0;                 // RL16
		endcase
	end

	// transmit port signals
	logic tx_sig;
	always_comb begin
		case (pin6_signal_select)
			3'h0: tx_sig = tx_stat.pass_and;         // RL8
			3'h1: tx_sig = tx_stat.pass_or;          // RL8
			3'h2: tx_sig = tx_stat.frame_valid;      // RL9
			3'h3: tx_sig = tx_stat.line_valid;       // RL10
			3'h4: tx_sig = tx_stat.synced;           // RL11
			3'h5: tx_sig = tx_stat.irq;              // RL12
			default: tx_sig = 1'b0;                  // RL12
		endcase
	end

	// first level: source choice; reserved sources drive low
	logic sel_sig;
	always_comb begin
		case (pin6_source_select)
			P6MUX_SRC_RX0, P6MUX_SRC_RX1,
			P6MUX_SRC_RX2, P6MUX_SRC_RX3: sel_sig = rx_sig;   // RL1
			P6MUX_SRC_DEV: sel_sig = dev_sig;                 // RL1
			P6MUX_SRC_TX:  sel_sig = tx_sig;                  // RL1
			default:       sel_sig = 1'b0;                    // RL16
		endcase
	end

	// pin outputs registered; level forced low while the driver is off
	wire logic nxt_pin = pin6_drive_enable ? sel_sig : 1'b0;  // RL17
	wire logic nxt_oe  = pin6_drive_enable;                   // RL14

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_ff <= 1'b0;
			oe_ff  <= 1'b0;
		end else if (clk_en) begin
			pin_ff <= nxt_pin;
			oe_ff  <= nxt_oe;                                    // RL14
		end
	end
	assign pin6_o  = pin_ff;
	assign pin6_oe = oe_ff;

	// register storage; reset value leaves the driver off on port 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff    <= `P6MUX_CTRL_RESET;                     // RL15
			port_en_ff <= `P6MUX_ENABLE_RESET;
		end else if (clk_en) begin
			if (wr_ctrl) ctrl_ff <= wdata_ff[7:0];
			if (wr_en) port_en_ff <= wdata_ff[3:0];
		end
	end

	// write address and data holding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			awaddr_ff  <= 12'h000;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
		end else if (clk_en) begin
			if (aw_take) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff  <= {s_axi_awaddr[11:2], 2'b00};
			end else if (wr_go) begin
				aw_hold_ff <= 1'b0;
			end
			if (w_take) begin
				w_hold_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end else if (wr_go) begin
				w_hold_ff <= 1'b0;
			end
		end
	end

	// handshake outputs; each ready only while its own channel holds nothing and no response is pending, so one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'b00;
		end else if (clk_en) begin
			s_axi_awready <= !aw_hold_ff && !aw_take && !s_axi_bvalid;
			s_axi_wready  <= !w_hold_ff && !w_take && !s_axi_bvalid;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= !ar_take && !s_axi_rvalid;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// the driver follows the enable bit one cycle later
	drive_follow_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
		clk_en |=> (pin6_oe == $past(pin6_drive_enable)))
		else $error("pin driver enable does not follow control bit");

	// a disabled driver never shows a high level
	idle_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL17
		!pin6_oe |-> !pin6_o)
		else $error("pin level high while driver disabled");

	// device select zero shows the local value
	local_value_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL13
		(clk_en && pin6_drive_enable && pin6_source_select == P6MUX_SRC_DEV
		 && pin6_signal_select == 3'h0) |=> (pin6_o == $past(pin6_local_value)))
		else $error("local value not driven");

	// reference terms for the checks below, written bit by bit so a slip in the
	// vector form of the aggregate does not hide itself
	wire logic lock_or_chk = (rx_stat[0].lock & port_en_ff[0]) |
	                         (rx_stat[1].lock & port_en_ff[1]) |
	                         (rx_stat[2].lock & port_en_ff[2]) |
	                         (rx_stat[3].lock & port_en_ff[3]);
	wire logic rx_lock_chk = rx_sel.lock;
	wire logic tx_irq_chk  = tx_stat.irq;

	// lock or over enabled ports
	lock_or_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
		(clk_en && pin6_drive_enable && pin6_source_select == P6MUX_SRC_DEV
		 && pin6_signal_select == 3'h1) |=> (pin6_o == $past(lock_or_chk)))
		else $error("lock or mismatch");

	// transmit interrupt selection
	tx_irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
		(clk_en && pin6_drive_enable && pin6_source_select == P6MUX_SRC_TX
		 && pin6_signal_select == 3'h5) |=> (pin6_o == $past(tx_irq_chk)))
		else $error("transmit interrupt not driven");

	// receive lock selection follows the chosen port
	rx_lock_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
		(clk_en && pin6_drive_enable && !pin6_source_select[2]
		 && pin6_signal_select == 3'h4)
		|=> (pin6_o == $past(rx_lock_chk)))
		else $error("receive lock not driven");

	// reserved sources stay low
	rsv_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL16
		(clk_en && pin6_source_select[0] && pin6_source_select[2]) |=> !pin6_o)
		else $error("reserved source not low");

	// control register reads back zero straight after reset
	reset_zero_a: assert property (@(posedge aclk) // RL15
		!aresetn |=> (ctrl_ff == 8'h00 && !pin6_oe))
		else $error("control register not cleared by reset");

endmodule : p6mux_top
